// ==== include/dsam_pkg.sv ====
// Package: register layout, source codes and constants for the alarm monitor
`default_nettype none
package dsam_pkg;
  // Register word addresses on the register port
  localparam logic [6:0] dsam_off_threshold_one = 7'h26;
  localparam logic [6:0] dsam_off_threshold_two = 7'h28;
  localparam logic [6:0] dsam_off_count_one     = 7'h2a;
  localparam logic [6:0] dsam_off_count_two     = 7'h2c;
  localparam logic [6:0] dsam_off_control       = 7'h2e;
  localparam logic [6:0] dsam_off_diag          = 7'h3c;
  // Reset values
  localparam logic [15:0] dsam_control_reset   = 16'h0000;
  localparam logic [15:0] dsam_count_reset     = 16'h0000;
  localparam logic [15:0] dsam_threshold_reset = 16'h0000;
  // Control field positions
  localparam int dsam_src_two_lsb = 12;
  localparam int dsam_src_one_lsb = 8;
  localparam int dsam_dyn_two_bit = 7;
  localparam int dsam_dyn_one_bit = 6;
  localparam int dsam_pol_two_bit = 5;
  localparam int dsam_pol_one_bit = 4;
  localparam int dsam_filt_bit    = 3;
  localparam int dsam_ind_en_bit  = 2;
  localparam int dsam_ind_pol_bit = 1;
  localparam int dsam_ind_sel_bit = 0;
  // Diagnostic flag positions
  localparam int dsam_diag_flag_one_bit = 8;
  localparam int dsam_diag_flag_two_bit = 9;
  // Window
  localparam int dsam_window_max = 256;
  localparam int dsam_sample_rate_sps = 1024;
  // Source selection codes
  localparam logic [3:0] dsam_src_disabled = 4'h0;
  localparam logic [3:0] dsam_src_gyro_x   = 4'h1;
  localparam logic [3:0] dsam_src_gyro_y   = 4'h2;
  localparam logic [3:0] dsam_src_gyro_z   = 4'h3;
  localparam logic [3:0] dsam_src_accel_x  = 4'h4;
  localparam logic [3:0] dsam_src_accel_y  = 4'h5;
  localparam logic [3:0] dsam_src_accel_z  = 4'h6;
  localparam logic [3:0] dsam_src_temp     = 4'h7;
  localparam logic [3:0] dsam_src_aux      = 4'h8;
  localparam logic [3:0] dsam_src_diag     = 4'h9;

  // One set of sensor words, one sample
  typedef struct packed {
    logic [15:0] gyro_x;
    logic [15:0] gyro_y;
    logic [15:0] gyro_z;
    logic [15:0] accel_x;
    logic [15:0] accel_y;
    logic [15:0] accel_z;
    logic [15:0] temp;
    logic [15:0] aux;
  } dsam_sensor_type;

  // Per-channel settings
  typedef struct packed {
    logic [3:0]  source;
    logic        dynamic;
    logic        greater;
    logic [7:0]  count;
    logic [15:0] threshold;
  } dsam_chan_cfg_type;
endpackage
`default_nettype wire

// ==== hw/dsam_channel.sv ====
// One alarm channel: source select, sample history, static or dynamic compare
`default_nettype none
module dsam_channel
  import dsam_pkg::*;
#(
  parameter int depth = dsam_window_max
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              sample_valid,
  input  wire dsam_sensor_type   sensors,
  input  wire logic              diag_nonzero,
  input  wire dsam_chan_cfg_type cfg,
  output var  logic              alarm
);
  logic [15:0] history [depth];
  logic [7:0]  wr_ptr;
  logic [7:0]  next_wr_ptr;
  logic        next_alarm;
  logic [15:0] value;
  logic [7:0]  window;
  logic [15:0] past;
  logic [16:0] delta;
  logic [15:0] compared;

  always_comb begin
    unique case (cfg.source)
      dsam_src_gyro_x:  value = sensors.gyro_x;
      dsam_src_gyro_y:  value = sensors.gyro_y;
      dsam_src_gyro_z:  value = sensors.gyro_z;
      dsam_src_accel_x: value = sensors.accel_x;
      dsam_src_accel_y: value = sensors.accel_y;
      dsam_src_accel_z: value = sensors.accel_z;
      dsam_src_temp:    value = sensors.temp;
      dsam_src_aux:     value = sensors.aux;
      default:          value = 16'h0000;
    endcase
  end

  always_comb begin
    window      = (cfg.count == 8'h00) ? 8'h01 : cfg.count;
    past        = history[8'(wr_ptr - window)];
    delta       = {value[15], value} - {past[15], past};
    compared    = cfg.dynamic ? delta[15:0] : value;
    next_wr_ptr = sample_valid ? 8'(wr_ptr + 8'h01) : wr_ptr;
    next_alarm  = alarm;
    if (sample_valid) begin
      if (cfg.source == dsam_src_disabled || cfg.source > dsam_src_diag) begin
        next_alarm = 1'b0;
      end else if (cfg.source == dsam_src_diag) begin
        next_alarm = diag_nonzero;
      end else if (cfg.greater) begin
        next_alarm = $signed(compared) > $signed(cfg.threshold);
      end else begin
        next_alarm = $signed(compared) < $signed(cfg.threshold);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr <= 8'h00;
      alarm  <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      alarm  <= next_alarm;
    end
  end

  always_ff @(posedge mclk) begin
    if (sample_valid) begin
      history[wr_ptr] <= value;
    end
  end

  disabled_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(sample_valid) && $past(cfg.source) == dsam_src_disabled |-> !alarm)
    else $error("disabled channel raised alarm");
endmodule
`default_nettype wire

// ==== hw/dsam_monitor.sv ====
// Two-channel alarm monitor with registers, diagnostic flags and indicator pins
`default_nettype none
module dsam_monitor
  import dsam_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            reg_write,
  input  wire logic            reg_read,
  input  wire logic [6:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  output var  logic [15:0]     reg_rdata,
  input  wire logic            sample_valid,
  input  wire dsam_sensor_type sensors_raw,
  input  wire dsam_sensor_type sensors_filtered,
  input  wire logic [15:0]     diag_other,
  output var  logic [15:0]     diagnostic_status,
  output var  logic            general_pin_one_out,
  output var  logic            general_pin_one_oe,
  output var  logic            general_pin_two_out,
  output var  logic            general_pin_two_oe
);
  logic [15:0]       alarm_control;
  logic [15:0]       alarm_one_sample_count;
  logic [15:0]       alarm_two_sample_count;
  logic [15:0]       alarm_one_threshold;
  logic [15:0]       alarm_two_threshold;
  logic [15:0]       next_alarm_control;
  logic [15:0]       next_alarm_one_sample_count;
  logic [15:0]       next_alarm_two_sample_count;
  logic [15:0]       next_alarm_one_threshold;
  logic [15:0]       next_alarm_two_threshold;
  logic [15:0]       next_reg_rdata;
  logic [15:0]       next_diagnostic_status;
  logic              next_pin_one_out;
  logic              next_pin_one_oe;
  logic              next_pin_two_out;
  logic              next_pin_two_oe;
  logic              alarm_one;
  logic              alarm_two;
  logic              diag_nonzero;
  logic              asserted;
  dsam_sensor_type   sensors;
  dsam_chan_cfg_type cfg_one;
  dsam_chan_cfg_type cfg_two;

  // Register port
  always_comb begin
    next_alarm_control          = alarm_control;
    next_alarm_one_sample_count = alarm_one_sample_count;
    next_alarm_two_sample_count = alarm_two_sample_count;
    next_alarm_one_threshold    = alarm_one_threshold;
    next_alarm_two_threshold    = alarm_two_threshold;
    if (reg_write) begin
      unique case (reg_addr)
        dsam_off_control:       next_alarm_control = reg_wdata;
        dsam_off_count_one:     next_alarm_one_sample_count = {8'h00, reg_wdata[7:0]};
        dsam_off_count_two:     next_alarm_two_sample_count = {8'h00, reg_wdata[7:0]};
        dsam_off_threshold_one: next_alarm_one_threshold = reg_wdata;
        dsam_off_threshold_two: next_alarm_two_threshold = reg_wdata;
        default: ;
      endcase
    end
    next_reg_rdata = reg_rdata;
    if (reg_read) begin
      unique case (reg_addr)
        dsam_off_control:       next_reg_rdata = alarm_control;
        dsam_off_count_one:     next_reg_rdata = alarm_one_sample_count;
        dsam_off_count_two:     next_reg_rdata = alarm_two_sample_count;
        dsam_off_threshold_one: next_reg_rdata = alarm_one_threshold;
        dsam_off_threshold_two: next_reg_rdata = alarm_two_threshold;
        dsam_off_diag:          next_reg_rdata = diagnostic_status;
        default:                next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alarm_control          <= dsam_control_reset;
      alarm_one_sample_count <= dsam_count_reset;
      alarm_two_sample_count <= dsam_count_reset;
      alarm_one_threshold    <= dsam_threshold_reset;
      alarm_two_threshold    <= dsam_threshold_reset;
      reg_rdata              <= 16'h0000;
    end else begin
      alarm_control          <= next_alarm_control;
      alarm_one_sample_count <= next_alarm_one_sample_count;
      alarm_two_sample_count <= next_alarm_two_sample_count;
      alarm_one_threshold    <= next_alarm_one_threshold;
      alarm_two_threshold    <= next_alarm_two_threshold;
      reg_rdata              <= next_reg_rdata;
    end
  end

  // Channel settings from control fields, sample count and threshold registers
  always_comb begin
    sensors = alarm_control[dsam_filt_bit] ? sensors_filtered : sensors_raw;
    diag_nonzero = ({diag_other[15:10], diag_other[7:0]} != 14'h0000) || (diagnostic_status != 16'h0000);
    cfg_one.source    = alarm_control[dsam_src_one_lsb +: 4];
    cfg_one.dynamic   = alarm_control[dsam_dyn_one_bit];
    cfg_one.greater   = alarm_control[dsam_pol_one_bit];
    cfg_one.count     = alarm_one_sample_count[7:0];
    cfg_one.threshold = alarm_one_threshold;
    cfg_two.source    = alarm_control[dsam_src_two_lsb +: 4];
    cfg_two.dynamic   = alarm_control[dsam_dyn_two_bit];
    cfg_two.greater   = alarm_control[dsam_pol_two_bit];
    cfg_two.count     = alarm_two_sample_count[7:0];
    cfg_two.threshold = alarm_two_threshold;
  end

  dsam_channel #(
    .depth(dsam_window_max)
  ) u_alarm_one (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .sample_valid (sample_valid),
    .sensors      (sensors),
    .diag_nonzero (diag_nonzero),
    .cfg          (cfg_one),
    .alarm        (alarm_one)
  );

  dsam_channel #(
    .depth(dsam_window_max)
  ) u_alarm_two (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .sample_valid (sample_valid),
    .sensors      (sensors),
    .diag_nonzero (diag_nonzero),
    .cfg          (cfg_two),
    .alarm        (alarm_two)
  );

  // Diagnostic word and indicator pins
  always_comb begin
    next_diagnostic_status = diag_other;
    next_diagnostic_status[dsam_diag_flag_one_bit] = alarm_one;
    next_diagnostic_status[dsam_diag_flag_two_bit] = alarm_two;
    asserted = alarm_one || alarm_two;
    next_pin_one_out = 1'b0;
    next_pin_one_oe  = 1'b0;
    next_pin_two_out = 1'b0;
    next_pin_two_oe  = 1'b0;
    if (alarm_control[dsam_ind_en_bit]) begin
      if (alarm_control[dsam_ind_sel_bit]) begin
        next_pin_two_oe  = 1'b1;
        next_pin_two_out = asserted ~^ alarm_control[dsam_ind_pol_bit];
      end else begin
        next_pin_one_oe  = 1'b1;
        next_pin_one_out = asserted ~^ alarm_control[dsam_ind_pol_bit];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      diagnostic_status   <= 16'h0000;
      general_pin_one_out <= 1'b0;
      general_pin_one_oe  <= 1'b0;
      general_pin_two_out <= 1'b0;
      general_pin_two_oe  <= 1'b0;
    end else begin
      diagnostic_status   <= next_diagnostic_status;
      general_pin_one_out <= next_pin_one_out;
      general_pin_one_oe  <= next_pin_one_oe;
      general_pin_two_out <= next_pin_two_out;
      general_pin_two_oe  <= next_pin_two_oe;
    end
  end

  control_reset_a: assert property (@(posedge mclk)
    $rose(reset_n) |-> alarm_control == 16'h0000 && alarm_one_sample_count == 16'h0000)
    else $error("control not zero after reset");

  count_upper_a: assert property (@(posedge mclk) disable iff (!reset_n)
    alarm_one_sample_count[15:8] == 8'h00 && alarm_two_sample_count[15:8] == 8'h00)
    else $error("sample count upper bits set");

  flag_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    diagnostic_status[9:8] == $past({alarm_two, alarm_one}))
    else $error("diagnostic flags lag alarms");

  pin_disabled_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(alarm_control[dsam_ind_en_bit]) |-> !general_pin_one_oe && !general_pin_two_oe)
    else $error("indicator driven while disabled");

  pin_route_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(alarm_control[dsam_ind_en_bit]) |->
      general_pin_two_oe == $past(alarm_control[dsam_ind_sel_bit]) &&
      general_pin_one_oe == !$past(alarm_control[dsam_ind_sel_bit]))
    else $error("indicator on wrong pin");

  pin_level_a: assert property (@(posedge mclk) disable iff (!reset_n)
    general_pin_two_oe |-> general_pin_two_out == ($past(asserted) == $past(alarm_control[dsam_ind_pol_bit])))
    else $error("indicator level wrong");

  write_ctrl_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_write && reg_addr == dsam_off_control |=> alarm_control == $past(reg_wdata))
    else $error("control write lost");

  static_cmp_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && cfg_one.source == dsam_src_accel_z && !cfg_one.dynamic && !cfg_one.greater
      |=> alarm_one == ($signed($past(sensors.accel_z)) < $signed($past(cfg_one.threshold))))
    else $error("static compare wrong");

  pin_one_level_a: assert property (@(posedge mclk) disable iff (!reset_n)
    general_pin_one_oe |-> general_pin_one_out == ($past(asserted) == $past(alarm_control[dsam_ind_pol_bit])))
    else $error("indicator one level wrong");

  pin_idle_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (general_pin_one_oe || !general_pin_one_out) && (general_pin_two_oe || !general_pin_two_out))
    else $error("undriven indicator pin not low");

  one_pin_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(general_pin_one_oe && general_pin_two_oe))
    else $error("both indicator pins driven");

  count_one_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_write && reg_addr == dsam_off_count_one |=> alarm_one_sample_count == {8'h00, $past(reg_wdata[7:0])})
    else $error("count one write lost");

  count_two_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_write && reg_addr == dsam_off_count_two |=> alarm_two_sample_count == {8'h00, $past(reg_wdata[7:0])})
    else $error("count two write lost");

  thresh_one_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_write && reg_addr == dsam_off_threshold_one |=> alarm_one_threshold == $past(reg_wdata))
    else $error("threshold one write lost");

  thresh_two_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_write && reg_addr == dsam_off_threshold_two |=> alarm_two_threshold == $past(reg_wdata))
    else $error("threshold two write lost");

  read_control_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_read && reg_addr == dsam_off_control |=> reg_rdata == $past(alarm_control))
    else $error("control read wrong");

  read_diag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_read && reg_addr == dsam_off_diag |=> reg_rdata == $past(diagnostic_status))
    else $error("diagnostic read wrong");

  read_count_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_read && reg_addr == dsam_off_count_two |=> reg_rdata == $past(alarm_two_sample_count))
    else $error("count read wrong");

  read_thresh_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_read && reg_addr == dsam_off_threshold_one |=> reg_rdata == $past(alarm_one_threshold))
    else $error("threshold read wrong");

  diag_copy_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(reset_n) |-> {diagnostic_status[15:10], diagnostic_status[7:0]} ==
      {$past(diag_other[15:10]), $past(diag_other[7:0])})
    else $error("other diagnostic bits lost");

  alarm_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !sample_valid |=> $stable(alarm_one) && $stable(alarm_two))
    else $error("alarm changed without sample");

  diag_source_two_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && cfg_two.source == dsam_src_diag |=> alarm_two == $past(diag_nonzero))
    else $error("alarm two diagnostic source wrong");

  diag_source_one_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && cfg_one.source == dsam_src_diag |=> alarm_one == $past(diag_nonzero))
    else $error("alarm one diagnostic source wrong");

  bad_code_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && cfg_two.source > dsam_src_diag |=> !alarm_two)
    else $error("unused source code raised alarm");

  static_gt_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && cfg_two.source == dsam_src_gyro_x && !cfg_two.dynamic && cfg_two.greater
      |=> alarm_two == ($signed($past(sensors.gyro_x)) > $signed($past(cfg_two.threshold))))
    else $error("static greater compare wrong");

  raw_static_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sample_valid && !alarm_control[dsam_filt_bit] && cfg_one.source == dsam_src_accel_z && !cfg_one.dynamic
      |=> alarm_one == ($signed($past(sensors_raw.accel_z)) < $signed($past(cfg_one.threshold))) == !$past(cfg_one.greater)
        || $past(cfg_one.greater))
    else $error("unfiltered source not used");

  reset_pins_a: assert property (@(posedge mclk)
    $rose(reset_n) |-> !general_pin_one_oe && !general_pin_two_oe && diagnostic_status == 16'h0000)
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ==== test/dsam_host.sv ====
// Host model that reads and writes the alarm monitor registers
`default_nettype none
module dsam_host (
  input  wire logic        mclk,
  input  wire logic [15:0] reg_rdata,
  output var  logic        reg_write,
  output var  logic        reg_read,
  output var  logic [6:0]  reg_addr,
  output var  logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 16'h0000;
  end
  // One-cycle write strobe, then address and data scrambled
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read strobe, data taken once the strobe edge has landed
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the two-channel alarm monitor
`default_nettype none
module tb_top;
  import dsam_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic            mclk = 1'b0;
  logic            reset_n = 1'b0;
  logic            sample_valid = 1'b0;
  dsam_sensor_type sensors_raw = '0;
  dsam_sensor_type sensors_filtered = '0;
  logic [15:0]     diag_other = 16'h0001;
  logic [15:0]     diagnostic_status;
  logic            p1_out, p1_oe, p2_out, p2_oe;
  logic            reg_write, reg_read;
  logic [6:0]      reg_addr;
  logic [15:0]     reg_wdata, reg_rdata;
  dsam_sensor_type hist_raw[$];
  dsam_sensor_type hist_filt[$];
  int              fail_count = 0;
  int              checks = 0;
  int              cyc = 0;
  logic [31:0]     seed = 32'd11394;
  logic [6:0]      ra [4] = '{dsam_off_control, dsam_off_count_one, dsam_off_count_two, 7'h00};

  always #2.5 mclk = ~mclk;

  dsam_host host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  dsam_monitor dut (.mclk(mclk), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sensors_raw(sensors_raw), .sensors_filtered(sensors_filtered), .diag_other(diag_other),
    .diagnostic_status(diagnostic_status), .general_pin_one_out(p1_out), .general_pin_one_oe(p1_oe),
    .general_pin_two_out(p2_out), .general_pin_two_oe(p2_oe));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Source word by code, codes 1 to 8 in struct order
  function automatic logic [15:0] pick(logic [127:0] v, logic [3:0] c);
    return v[143 - 16 * int'(c) -: 16];
  endfunction
  // Expected alarm of one channel on the newest sample
  function automatic logic chan(logic [3:0] src, logic dyn, logic gt, logic [15:0] cnt, logic [15:0] thr,
                                logic filt);
    int          n;
    logic [15:0] q;
    dsam_sensor_type h[$];
    n = (cnt[7:0] == 8'h00) ? 1 : int'(cnt[7:0]);
    if (src == dsam_src_diag) return 1'b1;
    if (src == dsam_src_disabled || src > dsam_src_diag) return 1'b0;
    h = filt ? hist_filt : hist_raw;
    q = pick(h[$], src);
    if (dyn) q = q - pick(h[$ - n], src);
    return gt ? ($signed(q) > $signed(thr)) : ($signed(q) < $signed(thr));
  endfunction

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pins(input logic [3:0] got, input logic [3:0] exp);
    cmp_word({12'h000, got}, {12'h000, exp});
  endtask
  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One sample pulse with fresh random sensor sets
  task automatic sample();
    dsam_sensor_type r, f;
    logic [31:0]     d;
    r = {xs(), xs(), xs(), xs()};
    f = {xs(), xs(), xs(), xs()};
    d = xs() | 32'h1;
    hist_raw.push_back(r);
    hist_filt.push_back(f);
    @(posedge mclk);
    sample_valid     <= 1'b1;
    sensors_raw      <= r;
    sensors_filtered <= f;
    diag_other       <= d[15:0];
    @(posedge mclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // Program one setup, then check the last samples of a run of ten
  task automatic run_cfg(input logic [15:0] ctrl);
    logic [15:0] t1, t2, c1, c2, d, ed;
    logic        any, en, sel, lv;
    logic [1:0]  al;
    t1 = 16'(xs());
    t2 = 16'(xs());
    c1 = 16'(xs()) & 16'hff07;
    c2 = 16'(xs()) & 16'hff07;
    en = ctrl[dsam_ind_en_bit];
    sel = ctrl[dsam_ind_sel_bit];
    ed = 16'h0000;
    host.wr(dsam_off_control, ctrl);
    host.wr(dsam_off_threshold_one, t1);
    host.wr(dsam_off_threshold_two, t2);
    host.wr(dsam_off_count_one, c1);
    host.wr(dsam_off_count_two, c2);
    host.rd(dsam_off_count_one, d);
    cmp_word(d, {8'h00, c1[7:0]});
    host.rd(dsam_off_count_two, d);
    cmp_word(d, {8'h00, c2[7:0]});
    host.rd(dsam_off_threshold_two, d);
    cmp_word(d, t2);
    host.rd(dsam_off_control, d);
    cmp_word(d, ctrl);
    for (int k = 0; k < 10; k++) begin
      sample();
      if (k >= 8) begin
        al[0] = chan(ctrl[11:8], ctrl[6], ctrl[4], c1, t1, ctrl[3]);
        al[1] = chan(ctrl[15:12], ctrl[7], ctrl[5], c2, t2, ctrl[3]);
        any = |al;
        lv = ctrl[dsam_ind_pol_bit] ~^ any;
        ed = {diag_other[15:10], al, diag_other[7:0]};
        cmp_word(diagnostic_status, ed);
        cmp_pins({p1_oe, p1_out, p2_oe, p2_out}, {en & ~sel, en & ~sel & lv, en & sel, en & sel & lv});
      end
    end
    host.rd(dsam_off_diag, d);
    cmp_word(d, ed);
  endtask

  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    logic [15:0] d;
    logic [31:0] r;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (ra[i]) begin
      host.rd(ra[i], d);
      cmp_word(d, 16'h0000);
    end
    run_cfg(16'h36af);
    for (int i = 0; i < 30; i++) begin
      r = xs();
      run_cfg({4'(i % 16), 4'((i * 7 + 3) % 10), r[7:0]});
    end
    test_done();
  end
endmodule
`default_nettype wire
